// ---- verification/frame_source.sv ----
// received byte stream source standing in for the line side of the filter
`timescale 1ns/1ps
module frame_source (
  // clock
  input wire logic ref_clk,
  // frame stream
  output logic [7:0] rxData,
  output logic rxDataValid,
  output logic rxFrameEnd,
  output logic rxCrcBad
);
  logic [7:0] bytes[$];
  initial begin
    rxData = 8'h00;
    rxDataValid = 1'b0;
    rxFrameEnd = 1'b0;
    rxCrcBad = 1'b0;
  end
  // idle lines carry the inverse of the last value, so nothing stale passes for fresh
  task automatic send(input logic bad);
    logic [7:0] b;
    while (bytes.size() > 0) begin
      b = bytes.pop_front();
      @(posedge ref_clk);
      rxData <= b;
      rxDataValid <= 1'b1;
      @(posedge ref_clk);
      rxData <= ~b;
      rxDataValid <= 1'b0;
    end
    @(posedge ref_clk);
    rxFrameEnd <= 1'b1;
    rxCrcBad <= bad;
    @(posedge ref_clk);
    rxFrameEnd <= 1'b0;
    rxCrcBad <= ~bad;
  endtask : send
endmodule : frame_source

// ---- verification/wake_on_lan_receive_config_properties.sv ----
// concurrent checks on the wake receive filter ports
`timescale 1ns/1ps
module wake_on_lan_receive_config_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdData,
  // frame stream
  input wire logic [7:0] rxData,
  input wire logic rxDataValid,
  input wire logic rxFrameEnd,
  input wire logic rxCrcBad,
  // indications
  input wire logic wakeOut,
  input wire logic irq,
  input wire logic intSourceWake
);
  logic [15:0] cfgReg;
  logic [15:0] maskReg;
  logic [7:0] hiLen;
  logic cfgWr;
  int pulseLen;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  assign cfgWr = regWr && regAddr == wake_on_lan_pkg::CFG_ADDR;
  // shadow copies of the settings, so each check knows the mode in force
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cfgReg <= wake_on_lan_pkg::CFG_RESET;
    end else if (cfgWr) begin
      cfgReg <= regWrData & wake_on_lan_pkg::CFG_WRITABLE;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      maskReg <= 16'h0000;
    end else if (regWr && regAddr == wake_on_lan_pkg::INT_MASK_ADDR) begin
      maskReg <= regWrData & wake_on_lan_pkg::EVENT_MASK;
    end
  end
  // run length of the wake output; it wraps in level mode, where nothing reads it
  always_ff @(posedge ref_clk) begin
    hiLen <= (resetn && wakeOut) ? hiLen + 8'h01 : 8'h00;
  end
  always_comb begin
    case (cfgReg[10:9])
      2'b00: pulseLen = wake_on_lan_pkg::PULSE_CNT0;
      2'b01: pulseLen = wake_on_lan_pkg::PULSE_CNT1;
      2'b10: pulseLen = wake_on_lan_pkg::PULSE_CNT2;
      default: pulseLen = wake_on_lan_pkg::PULSE_CNT3;
    endcase
  end
  sequence heldLevel;
    wakeOut && cfgReg[8] && !cfgWr;
  endsequence
  sequence clearWrite;
    cfgWr && regWrData[11] && regWrData[8] && cfgReg[8] && !rxFrameEnd;
  endsequence
  clear_reads_zero_a: assert property (
    regRd && regAddr == wake_on_lan_pkg::CFG_ADDR |=> !regRdData[11])
    else $error("level-clear bit read back as one");
  level_clear_a: assert property (clearWrite |-> ##[1:2] !wakeOut)
    else $error("level wake not dropped by clear write");
  level_hold_a: assert property (heldLevel |=> wakeOut)
    else $error("level wake dropped without clear");
  pulse_length_a: assert property (
    $fell(wakeOut) && !cfgReg[8] |-> int'(hiLen) == pulseLen)
    else $error("wake pulse length wrong");
  wake_disabled_a: assert property (
    rxFrameEnd && !cfgReg[7] && !wakeOut |=> !wakeOut)
    else $error("wake raised while detection disabled");
  crc_gate_a: assert property (
    rxFrameEnd && rxCrcBad && cfgReg[12] && !wakeOut |=> !wakeOut)
    else $error("wake raised for gated bad crc frame");
  source_select_a: assert property (cfgWr && regWrData[7] |-> ##2 intSourceWake)
    else $error("interrupt source not switched to wake");
  irq_masked_a: assert property (
    maskReg == 16'h0000 && $past(maskReg) == 16'h0000 |-> !irq)
    else $error("interrupt high with all sources masked");
endmodule : wake_on_lan_receive_config_properties

bind wake_on_lan_receive_config wake_on_lan_receive_config_properties props (
  .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxData(rxData),
  .rxDataValid(rxDataValid), .rxFrameEnd(rxFrameEnd), .rxCrcBad(rxCrcBad),
  .wakeOut(wakeOut), .irq(irq), .intSourceWake(intSourceWake)
);

// ---- verification/wake_on_lan_receive_config_test.sv ----
// self-checking bench for the wake receive filter
`timescale 1ns/1ps
module wake_on_lan_receive_config_test;
  localparam int PLEN [4] = '{wake_on_lan_pkg::PULSE_CNT0, wake_on_lan_pkg::PULSE_CNT1,
    wake_on_lan_pkg::PULSE_CNT2, wake_on_lan_pkg::PULSE_CNT3};
  logic ref_clk;
  logic resetn;
  logic [15:0] regAddr;
  logic [15:0] regWrData;
  logic regWr;
  logic regRd;
  logic [15:0] regRdData;
  logic [7:0] rxData;
  logic rxDataValid;
  logic rxFrameEnd;
  logic rxCrcBad;
  logic wakeOut;
  logic irq;
  logic intSourceWake;
  int error_cnt;
  int checks;
  int hi;
  wake_on_lan_receive_config DUT (.ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .rxData(rxData), .rxDataValid(rxDataValid), .rxFrameEnd(rxFrameEnd),
    .rxCrcBad(rxCrcBad), .wakeOut(wakeOut), .irq(irq), .intSourceWake(intSourceWake));
  frame_source src (.ref_clk(ref_clk), .rxData(rxData), .rxDataValid(rxDataValid),
    .rxFrameEnd(rxFrameEnd), .rxCrcBad(rxCrcBad));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 cmp(regRdData, exp);
  endtask : rdchk
  // counts wake cycles over a window that starts at the frame end edge
  task automatic watch(input int n);
    hi = 0;
    for (int i = 0; i < n; i++) begin
      #1;
      if (wakeOut === 1'b1) hi++;
      @(posedge ref_clk);
    end
  endtask : watch
  // raw line order that the filter turns back into b; every mode is its own inverse
  function automatic logic [7:0] ro(input logic [1:0] m, input logic [7:0] b);
    case (m)
      2'b01: ro = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
      2'b10: ro = {b[3:0], b[7:4]};
      2'b11: ro = {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
      default: ro = b;
    endcase
  endfunction : ro
  // kind 0 magic, 1 right password, 2 wrong password, 3 pattern
  task automatic frame(input logic [1:0] m, input logic [7:0] sfd, input int kind,
    input logic bad);
    for (int i = 0; i < 7; i++) src.bytes.push_back(ro(m, 8'h55));
    src.bytes.push_back(ro(m, sfd));
    if (kind == 3) begin
      for (int i = 0; i < 20; i++) src.bytes.push_back(ro(m, 8'h10 + 8'(i)));
    end else begin
      for (int i = 0; i < 6; i++) src.bytes.push_back(ro(m, 8'hff));
      for (int i = 0; i < 96; i++) src.bytes.push_back(ro(m, 8'ha0 + 8'(i % 6)));
      for (int i = 0; i < 6 && kind > 0; i++) begin
        src.bytes.push_back(ro(m, 8'hc0 + 8'(i) + (kind == 2 ? 8'h08 : 8'h00)));
      end
    end
    src.send(bad);
  endtask : frame
  initial begin
    resetn = 1'b0;
    regAddr = 16'h0000;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    error_cnt = 0;
    checks = 0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    rdchk(16'h04a0, wake_on_lan_pkg::CFG_RESET);
    rdchk(16'h04a1, 16'h0000);
    rdchk(16'h04c0, 16'h0000);
    wr(16'h04a4, 16'ha0a1);
    wr(16'h04a3, 16'ha2a3);
    wr(16'h04a2, 16'ha4a5);
    wr(16'h04a5, 16'hc1c0);
    wr(16'h04a6, 16'hc3c2);
    wr(16'h04a7, 16'hc5c4);
    for (int k = 0; k < 8; k++) wr(16'h04a8 + 16'(k), {8'h11 + 8'(2 * k), 8'h10 + 8'(2 * k)});
    wr(16'h04b1, 16'h00e3);
    frame(2'b00, 8'hd5, 0, 1'b0);
    watch(20);
    cmp(16'(hi), 16'h0000);
    rdchk(16'h04a1, 16'h0000);
    // every reorder mode paired with the pulse length of the same code
    for (int m = 0; m < 4; m++) begin
      wr(16'h04a0, {2'(m), 2'b01, 1'b0, 2'(m), 1'b0, 8'h83});
      frame(2'(m), 8'hd5, 0, 1'b0);
      watch(120);
      cmp(16'(hi), 16'(PLEN[m]));
      rdchk(16'h04a1, 16'h1001);
      rdchk(16'h04a1, 16'h1000);
    end
    cmp({15'h0000, irq}, 16'h0001);
    cmp({15'h0000, intSourceWake}, 16'h0001);
    wr(16'h04b1, 16'h0000);
    wr(16'h04a0, 16'h3083);
    frame(2'b00, 8'hd5, 0, 1'b0);
    rdchk(16'h04a1, 16'h1080);
    frame(2'b00, 8'h5d, 0, 1'b0);
    rdchk(16'h04a1, 16'h1001);
    cmp({15'h0000, irq}, 16'h0000);
    wr(16'h04b1, 16'h00e3);
    repeat (3) @(posedge ref_clk);
    #1 cmp({15'h0000, irq}, 16'h0001);
    wr(16'h04b0, 16'h00e3);
    rdchk(16'h04b0, 16'h0000);
    cmp({15'h0000, irq}, 16'h0000);
    wr(16'h04a0, 16'h1083);
    frame(2'b00, 8'hd5, 0, 1'b1);
    watch(20);
    cmp(16'(hi), 16'h0000);
    rdchk(16'h04a1, 16'h1040);
    wr(16'h04a0, 16'h0083);
    frame(2'b00, 8'hd5, 0, 1'b1);
    rdchk(16'h04a1, 16'h1041);
    wr(16'h04a0, 16'h10a3);
    frame(2'b00, 8'hd5, 1, 1'b0);
    rdchk(16'h04a1, 16'h1001);
    frame(2'b00, 8'hd5, 2, 1'b0);
    rdchk(16'h04a1, 16'h1020);
    frame(2'b00, 8'hd5, 0, 1'b0);
    rdchk(16'h04a1, 16'h1020);
    wr(16'h04a0, 16'h1083);
    wr(16'h04b0, 16'h00e3);
    frame(2'b00, 8'hd5, 3, 1'b0);
    watch(20);
    rdchk(16'h04a1, 16'h1002);
    rdchk(16'h04b0, 16'h0002);
    wr(16'h04a0, 16'h1183);
    frame(2'b00, 8'hd5, 0, 1'b0);
    watch(150);
    cmp(16'(hi), 16'd150);
    frame(2'b00, 8'hd5, 0, 1'b0);
    watch(10);
    cmp(16'(hi), 16'd10);
    wr(16'h04a0, 16'h1983);
    @(posedge ref_clk);
    watch(10);
    cmp(16'(hi), 16'h0000);
    rdchk(16'h04a0, 16'h1183);
    rdchk(16'h04a4, 16'ha0a1);
    rdchk(16'h04a5, 16'hc1c0);
    rdchk(16'h04a9, 16'h1312);
    wr(16'h04a1, 16'h0000);
    rdchk(16'h04a1, 16'h0001);
    cmp({15'h0000, intSourceWake}, 16'h0000);
    // a second reset in mid-run must bring the configuration register back to its reset value
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rdchk(16'h04a0, wake_on_lan_pkg::CFG_RESET);
    cmp({15'h0000, wakeOut}, 16'h0000);
    conclude();
  end
  // the tests need about 4000 cycles; ten times that means a hang
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    conclude();
  end
endmodule : wake_on_lan_receive_config_test

// ---- verilog/pattern_store.sv ----
// eight-word pattern memory with two registered read ports
`timescale 1ns/1ps
module pattern_store (
  // clock
  input wire logic ref_clk,
  // write port
  input wire logic wrEn,
  input wire logic [2:0] wrAddr,
  input wire logic [15:0] wrData,
  // match read port
  input wire logic [2:0] matchAddr,
  output logic [15:0] matchData,
  // bus read port
  input wire logic [2:0] busAddr,
  output logic [15:0] busData
);
  logic [15:0] mem [0:7];

  // contents have no reset; software loads the pattern before enabling
  always_ff @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge ref_clk) begin
    matchData <= mem[matchAddr];
    busData <= mem[busAddr];
  end
endmodule : pattern_store

// ---- verilog/wake_on_lan_pkg.sv ----
// shared offsets, field positions, reset values and timing counts for the wake receive filter
package wake_on_lan_pkg;
  // register offsets (16-bit registers at their printed addresses)
  localparam logic [15:0] CFG_ADDR = 16'h04a0;
  localparam logic [15:0] STAT_ADDR = 16'h04a1;
  localparam logic [15:0] MAC1_ADDR = 16'h04a2;
  localparam logic [15:0] MAC2_ADDR = 16'h04a3;
  localparam logic [15:0] MAC3_ADDR = 16'h04a4;
  localparam logic [15:0] PWD1_ADDR = 16'h04a5;
  localparam logic [15:0] PWD2_ADDR = 16'h04a6;
  localparam logic [15:0] PWD3_ADDR = 16'h04a7;
  localparam logic [15:0] PAT_BASE_ADDR = 16'h04a8;
  localparam logic [15:0] PAT_LAST_ADDR = 16'h04af;
  localparam logic [15:0] INT_STAT_ADDR = 16'h04b0;
  localparam logic [15:0] INT_MASK_ADDR = 16'h04b1;

  // configuration fields
  localparam int ORDER_HI = 15;
  localparam int ORDER_LO = 14;
  localparam int SFD_SEL_BIT = 13;
  localparam int CRC_GATE_BIT = 12;
  localparam int LEVEL_CLR_BIT = 11;
  localparam int PULSE_HI = 10;
  localparam int PULSE_LO = 9;
  localparam int IND_SEL_BIT = 8;
  localparam int WAKE_EN_BIT = 7;
  localparam int PWD_EN_BIT = 5;
  localparam int PAT_EN_BIT = 1;
  localparam int MAGIC_EN_BIT = 0;
  localparam logic [15:0] CFG_RESET = 16'h1000;
  localparam logic [15:0] CFG_WRITABLE = 16'hf7ff;

  // status / interrupt event bits (same layout in both)
  localparam int SRC_SEL_BIT = 12;
  localparam int SFD_ERR_BIT = 7;
  localparam int BAD_CRC_BIT = 6;
  localparam int HACK_BIT = 5;
  localparam int PAT_BIT = 1;
  localparam int MAGIC_BIT = 0;
  localparam logic [15:0] EVENT_MASK = 16'h00e3;

  // frame constants
  localparam logic [7:0] SFD_NORMAL = 8'hd5;
  localparam logic [7:0] SFD_ALT = 8'h5d;
  localparam logic [7:0] PREAMBLE_A = 8'h55;
  localparam logic [7:0] PREAMBLE_B = 8'haa;
  localparam logic [7:0] SYNC_BYTE = 8'hff;
  localparam logic [2:0] SYNC_LEN = 3'h6;
  localparam logic [2:0] ADDR_LEN = 3'h6;
  localparam logic [3:0] ADDR_REPS_LAST = 4'hf;
  localparam logic [4:0] PATTERN_BYTES = 5'h10;

  // wake pulse: 8/16/32/64 periods of the 125 MHz clock, counted on ref_clk
  localparam int SLOW_PERIOD_PS = 8000;
  localparam int REF_PERIOD_PS = 5000;
  localparam int PULSE_BASE_CYCLES = 8;
  localparam int PULSE_CNT0 = (PULSE_BASE_CYCLES * SLOW_PERIOD_PS + REF_PERIOD_PS - 1)
    / REF_PERIOD_PS;
  localparam int PULSE_CNT1 = (2 * PULSE_BASE_CYCLES * SLOW_PERIOD_PS + REF_PERIOD_PS - 1)
    / REF_PERIOD_PS;
  localparam int PULSE_CNT2 = (4 * PULSE_BASE_CYCLES * SLOW_PERIOD_PS + REF_PERIOD_PS - 1)
    / REF_PERIOD_PS;
  localparam int PULSE_CNT3 = (8 * PULSE_BASE_CYCLES * SLOW_PERIOD_PS + REF_PERIOD_PS - 1)
    / REF_PERIOD_PS;

  typedef enum logic [2:0] {
    HUNT = 3'b001,
    BODY = 3'b010,
    SKIP = 3'b100
  } frame_state_t;
endpackage : wake_on_lan_pkg

// ---- verilog/wake_on_lan_receive_config.sv ----
// wake receive filter: configuration, frame matching, status and wake indication
`timescale 1ns/1ps
module wake_on_lan_receive_config (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  // received frame stream
  input wire logic [7:0] rxData,
  input wire logic rxDataValid,
  input wire logic rxFrameEnd,
  input wire logic rxCrcBad,
  // indications
  output logic wakeOut,
  output logic irq,
  output logic intSourceWake
);
  logic [15:0] cfg_reg;
  logic [15:0] stat_reg;
  logic [15:0] intStat_reg;
  logic [15:0] intMask_reg;
  logic [47:0] mac_reg;
  logic [47:0] pwd_reg;
  logic [15:0] rdData_reg;
  logic patRead_reg;
  wake_on_lan_pkg::frame_state_t state_reg;
  logic [2:0] syncCnt_reg;
  logic [1:0] stage_reg;
  logic [3:0] rep_reg;
  logic [2:0] idx_reg;
  logic magicSeen_reg;
  logic pwdOk_reg;
  logic [4:0] patIdx_reg;
  logic [4:0] patIdx_next;
  logic patOk_reg;
  logic [6:0] pulseCnt_reg;
  logic [15:0] matchWord;
  logic [15:0] patBusWord;

  function automatic logic [7:0] reorder(input logic [1:0] mode, input logic [7:0] b);
    logic [7:0] r;
    r = b;
    case (mode)
      2'h1: r = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
      2'h2: r = {b[3:0], b[7:4]};
      2'h3: r = {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
      default: r = b;
    endcase
    return r;
  endfunction : reorder

  // byte k of a 48-bit field, byte 0 in bits 47:40
  function automatic logic [7:0] pick(input logic [47:0] f, input logic [2:0] k);
    return f[8'(47 - 8 * int'(k)) -: 8];
  endfunction : pick

  function automatic logic isAddr(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction : isAddr

  wire logic wakeEn = cfg_reg[wake_on_lan_pkg::WAKE_EN_BIT];
  wire logic [7:0] rxByte = reorder(cfg_reg[wake_on_lan_pkg::ORDER_HI:wake_on_lan_pkg::ORDER_LO],
    rxData);
  wire logic [7:0] sfdByte = cfg_reg[wake_on_lan_pkg::SFD_SEL_BIT] ?
    wake_on_lan_pkg::SFD_ALT : wake_on_lan_pkg::SFD_NORMAL;
  wire logic takeByte = rxDataValid && wakeEn;
  wire logic isPreamble = rxByte == wake_on_lan_pkg::PREAMBLE_A ||
    rxByte == wake_on_lan_pkg::PREAMBLE_B;
  wire logic sfdHit = takeByte && state_reg == wake_on_lan_pkg::HUNT && rxByte == sfdByte;
  wire logic sfdErr = takeByte && state_reg == wake_on_lan_pkg::HUNT && rxByte != sfdByte &&
    !isPreamble;
  wire logic bodyByte = takeByte && state_reg == wake_on_lan_pkg::BODY;
  wire logic frameDone = rxFrameEnd && wakeEn && state_reg == wake_on_lan_pkg::BODY;
  wire logic gated = cfg_reg[wake_on_lan_pkg::CRC_GATE_BIT] && rxCrcBad;
  wire logic pwdNeeded = cfg_reg[wake_on_lan_pkg::PWD_EN_BIT];
  // a password cut short by the frame end counts as wrong
  wire logic pwdGood = pwdOk_reg && stage_reg == 2'h2;
  wire logic magicHit = frameDone && magicSeen_reg && (!pwdNeeded || pwdGood) && !gated;
  wire logic hackHit = frameDone && magicSeen_reg && pwdNeeded && !pwdGood;
  wire logic patHit = frameDone && patOk_reg && patIdx_reg == wake_on_lan_pkg::PATTERN_BYTES &&
    !gated;
  wire logic crcHit = frameDone && rxCrcBad;
  wire logic magicIrq = magicHit && cfg_reg[wake_on_lan_pkg::MAGIC_EN_BIT];
  wire logic patIrq = patHit && cfg_reg[wake_on_lan_pkg::PAT_EN_BIT];
  wire logic wakeFire = magicIrq || patIrq;
  wire logic [15:0] events = {8'h00, sfdErr, crcHit, hackHit, 3'h0, patHit, magicHit};
  wire logic [15:0] irqEvents = {8'h00, sfdErr, crcHit, hackHit, 3'h0, patIrq, magicIrq};
  wire logic cfgWr = regWr && isAddr(regAddr, wake_on_lan_pkg::CFG_ADDR);
  wire logic statRd = regRd && isAddr(regAddr, wake_on_lan_pkg::STAT_ADDR);
  wire logic patWr = regWr && regAddr >= wake_on_lan_pkg::PAT_BASE_ADDR &&
    regAddr <= wake_on_lan_pkg::PAT_LAST_ADDR;
  wire logic patRd = regRd && regAddr >= wake_on_lan_pkg::PAT_BASE_ADDR &&
    regAddr <= wake_on_lan_pkg::PAT_LAST_ADDR;
  wire logic levelMode = cfg_reg[wake_on_lan_pkg::IND_SEL_BIT];
  wire logic levelClr = cfgWr && regWrData[wake_on_lan_pkg::LEVEL_CLR_BIT];

  // configuration; the level-clear bit is never stored
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cfg_reg <= wake_on_lan_pkg::CFG_RESET;
    end else if (cfgWr) begin
      cfg_reg <= regWrData & wake_on_lan_pkg::CFG_WRITABLE;
    end
  end

  // address and password match data
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mac_reg <= 48'h0;
      pwd_reg <= 48'h0;
    end else if (regWr) begin
      case (regAddr)
        wake_on_lan_pkg::MAC3_ADDR: mac_reg[47:32] <= regWrData;
        wake_on_lan_pkg::MAC2_ADDR: mac_reg[31:16] <= regWrData;
        wake_on_lan_pkg::MAC1_ADDR: mac_reg[15:0] <= regWrData;
        wake_on_lan_pkg::PWD1_ADDR: pwd_reg[47:32] <= {regWrData[7:0], regWrData[15:8]};
        wake_on_lan_pkg::PWD2_ADDR: pwd_reg[31:16] <= {regWrData[7:0], regWrData[15:8]};
        wake_on_lan_pkg::PWD3_ADDR: pwd_reg[15:0] <= {regWrData[7:0], regWrData[15:8]};
        default: mac_reg <= mac_reg;
      endcase
    end
  end

  // latched status: a read clears bits 7:0, but an event in the same cycle survives
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stat_reg <= 16'h0000;
    end else begin
      if (statRd) begin
        stat_reg[7:0] <= events[7:0];
      end else begin
        stat_reg[7:0] <= stat_reg[7:0] | events[7:0];
      end
      if (cfgWr && regWrData[wake_on_lan_pkg::WAKE_EN_BIT]) begin
        stat_reg[wake_on_lan_pkg::SRC_SEL_BIT] <= 1'b1;
      end else if (regWr && isAddr(regAddr, wake_on_lan_pkg::STAT_ADDR)) begin
        stat_reg[wake_on_lan_pkg::SRC_SEL_BIT] <= regWrData[wake_on_lan_pkg::SRC_SEL_BIT];
      end
    end
  end

  // interrupt status (write one to clear, set wins) and mask
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      intStat_reg <= 16'h0000;
      intMask_reg <= 16'h0000;
      irq <= 1'b0;
    end else begin
      if (regWr && isAddr(regAddr, wake_on_lan_pkg::INT_STAT_ADDR)) begin
        intStat_reg <= (intStat_reg & ~regWrData) | irqEvents;
      end else begin
        intStat_reg <= intStat_reg | irqEvents;
      end
      if (regWr && isAddr(regAddr, wake_on_lan_pkg::INT_MASK_ADDR)) begin
        intMask_reg <= regWrData & wake_on_lan_pkg::EVENT_MASK;
      end
      irq <= |(intStat_reg & intMask_reg);
    end
  end

  // frame state: hunt for the delimiter, then the body until frame end
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg <= wake_on_lan_pkg::HUNT;
    end else if (!wakeEn || rxFrameEnd) begin
      state_reg <= wake_on_lan_pkg::HUNT;
    end else begin
      case (state_reg)
        wake_on_lan_pkg::HUNT: begin
          if (sfdHit) begin
            state_reg <= wake_on_lan_pkg::BODY;
          end else if (sfdErr) begin
            state_reg <= wake_on_lan_pkg::SKIP;
          end
        end
        wake_on_lan_pkg::BODY: state_reg <= wake_on_lan_pkg::BODY;
        wake_on_lan_pkg::SKIP: state_reg <= wake_on_lan_pkg::SKIP;
        default: state_reg <= wake_on_lan_pkg::HUNT;
      endcase
    end
  end

  // magic packet: six sync bytes, sixteen copies of the address, then the password
  always_ff @(posedge ref_clk) begin
    if (!resetn || sfdHit) begin
      syncCnt_reg <= 3'h0;
      stage_reg <= 2'h0;
      rep_reg <= 4'h0;
      idx_reg <= 3'h0;
      magicSeen_reg <= 1'b0;
      pwdOk_reg <= 1'b0;
    end else if (bodyByte && !magicSeen_reg) begin
      if (stage_reg == 2'h1 && rxByte == pick(mac_reg, idx_reg)) begin
        if (idx_reg == wake_on_lan_pkg::ADDR_LEN - 3'h1) begin
          idx_reg <= 3'h0;
          rep_reg <= rep_reg + 4'h1;
          if (rep_reg == wake_on_lan_pkg::ADDR_REPS_LAST) begin
            magicSeen_reg <= 1'b1;
            pwdOk_reg <= 1'b1;
          end
        end else begin
          idx_reg <= idx_reg + 3'h1;
        end
      end else if (rxByte == wake_on_lan_pkg::SYNC_BYTE) begin
        // a sync byte during a broken address run restarts the sync count
        if (stage_reg == 2'h1 || syncCnt_reg != wake_on_lan_pkg::SYNC_LEN - 3'h1) begin
          syncCnt_reg <= (stage_reg == 2'h1) ? 3'h1 : syncCnt_reg + 3'h1;
          stage_reg <= 2'h0;
        end else begin
          stage_reg <= 2'h1;
        end
        rep_reg <= 4'h0;
        idx_reg <= 3'h0;
      end else begin
        syncCnt_reg <= 3'h0;
        stage_reg <= 2'h0;
        rep_reg <= 4'h0;
        idx_reg <= 3'h0;
      end
    end else if (bodyByte && stage_reg != 2'h2) begin
      // password bytes follow the last address copy
      if (rxByte != pick(pwd_reg, idx_reg)) begin
        pwdOk_reg <= 1'b0;
      end
      idx_reg <= idx_reg + 3'h1;
      if (idx_reg == wake_on_lan_pkg::ADDR_LEN - 3'h1) begin
        stage_reg <= 2'h2;
      end
    end
  end

  // pattern: first bytes of the body against the stored pattern, fetched one byte ahead
  always_comb begin
    patIdx_next = patIdx_reg;
    if (sfdHit) begin
      patIdx_next = 5'h00;
    end else if (bodyByte && patIdx_reg != wake_on_lan_pkg::PATTERN_BYTES) begin
      patIdx_next = patIdx_reg + 5'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      patIdx_reg <= 5'h00;
      patOk_reg <= 1'b0;
    end else begin
      patIdx_reg <= patIdx_next;
      if (sfdHit) begin
        patOk_reg <= 1'b1;
      end else if (bodyByte && patIdx_reg != wake_on_lan_pkg::PATTERN_BYTES) begin
        if (rxByte != (patIdx_reg[0] ? matchWord[15:8] : matchWord[7:0])) begin
          patOk_reg <= 1'b0;
        end
      end
    end
  end

  pattern_store patternMem (
    .ref_clk(ref_clk),
    .wrEn(patWr),
    .wrAddr(regAddr[2:0]),
    .wrData(regWrData),
    .matchAddr(patIdx_next[3:1]),
    .matchData(matchWord),
    .busAddr(regAddr[2:0]),
    .busData(patBusWord)
  );

  // wake indication: a timed pulse, or a level held until software clears it
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wakeOut <= 1'b0;
      pulseCnt_reg <= 7'h00;
    end else if (levelMode) begin
      pulseCnt_reg <= 7'h00;
      if (wakeFire) begin
        wakeOut <= 1'b1;
      end else if (levelClr) begin
        wakeOut <= 1'b0;
      end
    end else if (wakeFire) begin
      wakeOut <= 1'b1;
      case (cfg_reg[wake_on_lan_pkg::PULSE_HI:wake_on_lan_pkg::PULSE_LO])
        2'h1: pulseCnt_reg <= 7'(wake_on_lan_pkg::PULSE_CNT1 - 1);
        2'h2: pulseCnt_reg <= 7'(wake_on_lan_pkg::PULSE_CNT2 - 1);
        2'h3: pulseCnt_reg <= 7'(wake_on_lan_pkg::PULSE_CNT3 - 1);
        default: pulseCnt_reg <= 7'(wake_on_lan_pkg::PULSE_CNT0 - 1);
      endcase
    end else if (pulseCnt_reg != 7'h00) begin
      pulseCnt_reg <= pulseCnt_reg - 7'h01;
    end else begin
      wakeOut <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      intSourceWake <= 1'b0;
    end else begin
      intSourceWake <= stat_reg[wake_on_lan_pkg::SRC_SEL_BIT];
    end
  end

  // read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdData_reg <= 16'h0000;
      patRead_reg <= 1'b0;
    end else begin
      patRead_reg <= patRd;
      rdData_reg <= 16'h0000;
      if (regRd) begin
        case (regAddr)
          wake_on_lan_pkg::CFG_ADDR: rdData_reg <= cfg_reg;
          wake_on_lan_pkg::STAT_ADDR: rdData_reg <= stat_reg;
          wake_on_lan_pkg::MAC3_ADDR: rdData_reg <= mac_reg[47:32];
          wake_on_lan_pkg::MAC2_ADDR: rdData_reg <= mac_reg[31:16];
          wake_on_lan_pkg::MAC1_ADDR: rdData_reg <= mac_reg[15:0];
          wake_on_lan_pkg::PWD1_ADDR: rdData_reg <= {pwd_reg[39:32], pwd_reg[47:40]};
          wake_on_lan_pkg::PWD2_ADDR: rdData_reg <= {pwd_reg[23:16], pwd_reg[31:24]};
          wake_on_lan_pkg::PWD3_ADDR: rdData_reg <= {pwd_reg[7:0], pwd_reg[15:8]};
          wake_on_lan_pkg::INT_STAT_ADDR: rdData_reg <= intStat_reg;
          wake_on_lan_pkg::INT_MASK_ADDR: rdData_reg <= intMask_reg;
          default: rdData_reg <= 16'h0000;
        endcase
      end
    end
  end

  // pattern words come from the memory's own output register
  assign regRdData = patRead_reg ? patBusWord : rdData_reg;
endmodule : wake_on_lan_receive_config
